/* File: rtl/bst_defs.svh */
// Constants of the boundary scan test port: instruction codes, register
// widths, capture values. Included by the test port module, its checker and the bench.
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

`define BST_IR_W 3
`define BST_ID_W 32
`define BST_BYP_W 1

`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLE 3'h2
`define BST_OP_CLAMP 3'h3
`define BST_OP_HIGHZ 3'h4
`define BST_OP_BYPASS 3'h7

// Fixed pattern loaded in Capture-IR, low two bits 01 as usual
`define BST_IR_CAPTURE 3'h1
`define BST_IR_RESET `BST_OP_IDCODE
`define BST_BYP_CAPTURE 1'h0

// Identification word fields
`define BST_ID_VER_LSB 28
`define BST_ID_PART_LSB 12
`define BST_ID_MFR_LSB 1

`endif

/* File: rtl/bst_pkg.sv */
// Types shared by the boundary scan test port.
// Assumes nothing beyond a SystemVerilog compiler.
package bst_pkg;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE,
      TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
      TAP_EXIT2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR,
      TAP_EXIT2_IR, TAP_UPD_IR
   } bst_state_t;

   typedef enum logic [1:0] {
      BST_SEL_BYP, BST_SEL_ID, BST_SEL_BSR
   } bst_sel_t;

   // Pin mode as seen by the pin multiplexers
   typedef struct packed {
      logic drive;
      logic highz;
   } bst_mode_t;

endpackage : bst_pkg

/* File: rtl/bst_tap.sv */
// Boundary scan test access port: TAP controller, instruction register,
// bypass, identification and boundary registers, and the pin multiplexers.
// Assumes scan_clk comes from an external tester and may stop between scans;
// pins and core signals are sampled across into the domain that reads them.
`include "bst_defs.svh"

// How it works
// - Controller samples mode_select on each rising scan_clk edge and moves only then, or at once to Test-Logic-Reset on scan_reset_n low.
// - Power-up gives Test-Logic-Reset, instruction IDCODE, system logic runs normally.
// - Select-DR-Scan holds registers; low goes Capture-DR, high goes Select-IR-Scan.
// - Capture-DR loads the selected register where allowed; low Shift-DR, high Exit1-DR.
// - Shift-DR shifts selected register toward scan_out; other registers hold.
// - Exit1-DR goes Update-DR on high, Pause-DR on low.
// - Pause-DR stops shifting and holds; high moves to Exit2-DR.
// - Exit2-DR goes Update-DR on high, back to Shift-DR on low.
// - Update-DR falling edge copies shift path into output latches; then idle or select.
// - Select-IR-Scan holds everything; low Capture-IR, high Test-Logic-Reset.
// - Capture-IR loads a fixed value; high Exit1-IR, low Shift-IR.
// - Shift-IR shifts instruction stage toward scan_out; other registers hold.
// - IR exit and pause states branch like their DR counterparts.
// - Falling edge in Update-IR latches the new current instruction.
// - Instruction shift stage and latched output are three bits each.
// - Code 010 selects boundary register; capture samples pins, normal operation kept.
// - Code 000 selects boundary register and drives pins from its latched outputs.
// - Code 111 routes scan_in to scan_out through the one-bit bypass stage.
// - Code 001 selects the identification register, loaded at capture, shifted out.
// - Code 100 floats every output pin and selects the bypass stage.
// - Code 011 holds pins from the boundary latches and selects the bypass stage.
// - Identification register has 32 shift stages and a 32-bit latched output.
module bst_tap
   import bst_pkg::*;
#(
   parameter int NPIN = 8,
   // Identification fields: arbitrary values, not any real part
   parameter logic [3:0] ID_VERSION = 4'h1,
   parameter logic [15:0] ID_PART = 16'h5a5a,
   parameter logic [10:0] ID_MAKER = 11'h123
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scan_clk,
   input wire logic scan_reset_n,
   input wire logic mode_select,
   input wire logic scan_in,
   output logic scan_out,
   output logic scan_out_oe,
   input wire logic [NPIN-1:0] core_out,
   input wire logic [NPIN-1:0] core_oe,
   output logic [NPIN-1:0] core_in,
   input wire logic [NPIN-1:0] pin_in,
   output logic [NPIN-1:0] pin_out,
   output logic [NPIN-1:0] pin_oe
);

   localparam int BSR_W = 3 * NPIN;
   localparam logic [`BST_ID_W-1:0] ID_WORD =
      {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

   // ---------------------------------------------------------------
   // Scan clock domain
   // ---------------------------------------------------------------
   bst_state_t state_ff;
   bst_state_t nxt_state;
   logic [`BST_IR_W-1:0] ir_shift_ff;
   logic [`BST_IR_W-1:0] ir_ff;
   logic byp_ff;
   logic [`BST_ID_W-1:0] id_shift_ff;
   logic [`BST_ID_W-1:0] id_upd_ff;
   logic [BSR_W-1:0] bsr_shift_ff;
   logic [BSR_W-1:0] bsr_upd_ff;
   logic bsr_tgl_ff;
   logic [BSR_W-1:0] smp_meta_ff;
   logic [BSR_W-1:0] smp_ff;
   bst_sel_t sel;
   logic serial_bit;
   logic shifting;

   // Five rising edges with mode_select high reach Test-Logic-Reset from any state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         TAP_RESET: begin
            nxt_state = mode_select ? TAP_RESET : TAP_IDLE;
         end
         TAP_IDLE: begin
            nxt_state = mode_select ? TAP_SEL_DR : TAP_IDLE;
         end
         TAP_SEL_DR: begin
            nxt_state = mode_select ? TAP_SEL_IR : TAP_CAP_DR;
         end
         TAP_CAP_DR: begin
            nxt_state = mode_select ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         end
         TAP_SHIFT_DR: begin
            nxt_state = mode_select ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         end
         TAP_EXIT1_DR: begin
            nxt_state = mode_select ? TAP_UPD_DR : TAP_PAUSE_DR;
         end
         TAP_PAUSE_DR: begin
            nxt_state = mode_select ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         end
         TAP_EXIT2_DR: begin
            nxt_state = mode_select ? TAP_UPD_DR : TAP_SHIFT_DR;
         end
         TAP_UPD_DR: begin
            nxt_state = mode_select ? TAP_SEL_DR : TAP_IDLE;
         end
         TAP_SEL_IR: begin
            nxt_state = mode_select ? TAP_RESET : TAP_CAP_IR;
         end
         TAP_CAP_IR: begin
            nxt_state = mode_select ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         end
         TAP_SHIFT_IR: begin
            nxt_state = mode_select ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         end
         TAP_EXIT1_IR: begin
            nxt_state = mode_select ? TAP_UPD_IR : TAP_PAUSE_IR;
         end
         TAP_PAUSE_IR: begin
            nxt_state = mode_select ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         end
         TAP_EXIT2_IR: begin
            nxt_state = mode_select ? TAP_UPD_IR : TAP_SHIFT_IR;
         end
         TAP_UPD_IR: begin
            nxt_state = mode_select ? TAP_SEL_DR : TAP_IDLE;
         end
         default: begin
            nxt_state = TAP_RESET;
         end
      endcase
   end

   // The test reset pin acts without a clock since the tester may hold it stopped
   always_ff @(posedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         state_ff <= TAP_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Register selection from the current instruction
   always_comb begin
      case (ir_ff)
         `BST_OP_EXTEST, `BST_OP_SAMPLE: sel = BST_SEL_BSR;
         `BST_OP_IDCODE: sel = BST_SEL_ID;
         default: sel = BST_SEL_BYP;
      endcase
   end

   // Instruction shift stage
   always_ff @(posedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         ir_shift_ff <= `BST_IR_CAPTURE;
      end else if (state_ff == TAP_CAP_IR) begin
         ir_shift_ff <= `BST_IR_CAPTURE;
      end else if (state_ff == TAP_SHIFT_IR) begin
         ir_shift_ff <= {scan_in, ir_shift_ff[`BST_IR_W-1:1]};
      end
   end

   // Instruction latch; Test-Logic-Reset forces IDCODE on every falling edge
   always_ff @(negedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         ir_ff <= `BST_IR_RESET;
      end else if (state_ff == TAP_RESET) begin
         ir_ff <= `BST_IR_RESET;
      end else if (state_ff == TAP_UPD_IR) begin
         ir_ff <= ir_shift_ff;
      end
   end

   // Bypass stage
   always_ff @(posedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         byp_ff <= `BST_BYP_CAPTURE;
      end else if (sel == BST_SEL_BYP && state_ff == TAP_CAP_DR) begin
         byp_ff <= `BST_BYP_CAPTURE;
      end else if (sel == BST_SEL_BYP && state_ff == TAP_SHIFT_DR) begin
         byp_ff <= scan_in;
      end
   end

   // Identification register: loaded at capture, shifted toward scan_out
   always_ff @(posedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         id_shift_ff <= '0;
      end else if (sel == BST_SEL_ID && state_ff == TAP_CAP_DR) begin
         id_shift_ff <= ID_WORD;
      end else if (sel == BST_SEL_ID && state_ff == TAP_SHIFT_DR) begin
         id_shift_ff <= {scan_in, id_shift_ff[`BST_ID_W-1:1]};
      end
   end

   // Parallel copy of the identification word; nothing beyond the port reads it
   always_ff @(negedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         id_upd_ff <= '0;
      end else if (sel == BST_SEL_ID && state_ff == TAP_UPD_DR) begin
         id_upd_ff <= id_shift_ff;
      end
   end

   // Pin and core levels cross into the scan domain, one synchroniser per cell.
   // Cells are independent, so a skew of one bit between them is harmless.
   always_ff @(posedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         smp_meta_ff <= '0;
         smp_ff <= '0;
      end else begin
         smp_meta_ff <= {core_oe, core_out, pin_in};
         smp_ff <= smp_meta_ff;
      end
   end

   // Boundary register: inputs low, then output data, then output enables
   always_ff @(posedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         bsr_shift_ff <= '0;
      end else if (sel == BST_SEL_BSR && state_ff == TAP_CAP_DR) begin
         bsr_shift_ff <= smp_ff;
      end else if (sel == BST_SEL_BSR && state_ff == TAP_SHIFT_DR) begin
         bsr_shift_ff <= {scan_in, bsr_shift_ff[BSR_W-1:1]};
      end
   end

   // Latched outputs change only in Update-DR, so shifting never reaches the pins.
   // The toggle tells the system domain that a new word is stable.
   always_ff @(negedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         bsr_upd_ff <= '0;
         bsr_tgl_ff <= 1'b0;
      end else if (sel == BST_SEL_BSR && state_ff == TAP_UPD_DR) begin
         bsr_upd_ff <= bsr_shift_ff;
         bsr_tgl_ff <= ~bsr_tgl_ff;
      end
   end

   always_comb begin
      shifting = (state_ff == TAP_SHIFT_DR) || (state_ff == TAP_SHIFT_IR);
      if (state_ff == TAP_SHIFT_IR) begin
         serial_bit = ir_shift_ff[0];
      end else if (sel == BST_SEL_BSR) begin
         serial_bit = bsr_shift_ff[0];
      end else if (sel == BST_SEL_ID) begin
         serial_bit = id_shift_ff[0];
      end else begin
         serial_bit = byp_ff;
      end
   end

   // Serial output changes on the falling edge, giving the tester half a period
   always_ff @(negedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         scan_out <= 1'b0;
      end else begin
         scan_out <= serial_bit;
      end
   end

   // Enable follows the shift states so the line floats between scans
   always_ff @(negedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         scan_out_oe <= 1'b0;
      end else begin
         scan_out_oe <= shifting;
      end
   end

   // ---------------------------------------------------------------
   // System clock domain
   // ---------------------------------------------------------------
   bst_mode_t mode_scan_ff;
   bst_mode_t mode_meta_ff;
   bst_mode_t mode_ff;
   logic [2:0] tgl_ff;
   logic [BSR_W-1:0] bsr_word_ff;
   logic [NPIN-1:0] pin_meta_ff;
   logic [NPIN-1:0] pin_sync_ff;

   // Pin mode is a flop beside the instruction latch, so the system domain never
   // samples a decode that is still settling across several instruction bits
   always_ff @(negedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) begin
         mode_scan_ff <= '0;
      end else if (state_ff == TAP_RESET) begin
         mode_scan_ff <= '0;
      end else if (state_ff == TAP_UPD_IR) begin
         mode_scan_ff.drive <= (ir_shift_ff == `BST_OP_EXTEST) ||
            (ir_shift_ff == `BST_OP_CLAMP);
         mode_scan_ff.highz <= (ir_shift_ff == `BST_OP_HIGHZ);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode_meta_ff <= '0;
         mode_ff <= '0;
      end else begin
         mode_meta_ff <= mode_scan_ff;
         mode_ff <= mode_meta_ff;
      end
   end

   // Toggle handshake for the boundary word: the word is quiet long before
   // the next update, so it is safe to take once the toggle is seen.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tgl_ff <= '0;
      end else begin
         tgl_ff <= {tgl_ff[1:0], bsr_tgl_ff};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bsr_word_ff <= '0;
      end else if (tgl_ff[2] != tgl_ff[1]) begin
         bsr_word_ff <= bsr_upd_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
      end else begin
         pin_meta_ff <= pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   assign core_in = pin_sync_ff;

   // Pin multiplexers; in every other mode the core owns the pins
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         logic out_ff;
         logic oe_ff;
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               out_ff <= 1'b0;
               oe_ff <= 1'b0;
            end else if (mode_ff.highz) begin
               out_ff <= 1'b0;
               oe_ff <= 1'b0;
            end else if (mode_ff.drive) begin
               out_ff <= bsr_word_ff[NPIN + gi];
               oe_ff <= bsr_word_ff[2 * NPIN + gi];
            end else begin
               out_ff <= core_out[gi];
               oe_ff <= core_oe[gi];
            end
         end
         assign pin_out[gi] = out_ff;
         assign pin_oe[gi] = oe_ff;
      end
   endgenerate

endmodule // bst_tap

/* File: test/bst_tap_properties.sv */
// Checker of the scan port: follows the controller state and instruction.
// Assumes it is bound to bst_tap and sees only that module's ports.
`include "bst_defs.svh"
module bst_tap_properties
   import bst_pkg::*;
#(
   parameter int NPIN = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scan_clk,
   input wire logic scan_reset_n,
   input wire logic mode_select,
   input wire logic scan_in,
   input wire logic scan_out,
   input wire logic scan_out_oe,
   input wire logic [NPIN-1:0] core_in,
   input wire logic [NPIN-1:0] pin_in,
   input wire logic [NPIN-1:0] pin_out,
   input wire logic [NPIN-1:0] pin_oe
);
   localparam bst_state_t LO [16] = '{TAP_IDLE, TAP_IDLE, TAP_CAP_DR, TAP_SHIFT_DR,
      TAP_SHIFT_DR, TAP_PAUSE_DR, TAP_PAUSE_DR, TAP_SHIFT_DR, TAP_IDLE, TAP_CAP_IR,
      TAP_SHIFT_IR, TAP_SHIFT_IR, TAP_PAUSE_IR, TAP_PAUSE_IR, TAP_SHIFT_IR, TAP_IDLE};
   localparam bst_state_t HI [16] = '{TAP_RESET, TAP_SEL_DR, TAP_SEL_IR, TAP_EXIT1_DR,
      TAP_EXIT1_DR, TAP_UPD_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_DR, TAP_RESET,
      TAP_EXIT1_IR, TAP_EXIT1_IR, TAP_UPD_IR, TAP_EXIT2_IR, TAP_UPD_IR, TAP_SEL_DR};
   bst_state_t st_ff;
   logic [2:0] irs_ff;
   logic [2:0] ir_ff;
   logic byp;
   assign byp = ir_ff inside {3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   always_ff @(posedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) st_ff <= TAP_RESET;
      else st_ff <= mode_select ? HI[st_ff] : LO[st_ff];
   end
   always_ff @(posedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) irs_ff <= 3'h0;
      else if (st_ff == TAP_CAP_IR) irs_ff <= `BST_IR_CAPTURE;
      else if (st_ff == TAP_SHIFT_IR) irs_ff <= {scan_in, irs_ff[2:1]};
   end
   // Instruction latches on the falling edge, so it is stable at every rise
   always_ff @(negedge scan_clk or negedge scan_reset_n) begin
      if (!scan_reset_n) ir_ff <= `BST_OP_IDCODE;
      else if (st_ff == TAP_RESET) ir_ff <= `BST_OP_IDCODE;
      else if (st_ff == TAP_UPD_IR) ir_ff <= irs_ff;
   end
   sequence s_cap_ir;
      st_ff == TAP_CAP_IR ##1 st_ff == TAP_SHIFT_IR;
   endsequence
   sequence s_cap_id;
      (st_ff == TAP_CAP_DR && ir_ff == `BST_OP_IDCODE) ##1 st_ff == TAP_SHIFT_DR;
   endsequence
   sequence s_byp;
      (st_ff == TAP_SHIFT_DR && byp) ##1 st_ff == TAP_SHIFT_DR;
   endsequence
   AST_OE_SHIFT: assert property (@(posedge scan_clk) disable iff (!scan_reset_n)
      scan_out_oe == (st_ff inside {TAP_SHIFT_DR, TAP_SHIFT_IR}))
      else $error("serial output enable out of step");
   AST_CAP_IR: assert property (@(posedge scan_clk) disable iff (!scan_reset_n)
      s_cap_ir |-> scan_out) else $error("instruction capture bit wrong");
   AST_IR_SHIFT: assert property (@(posedge scan_clk) disable iff (!scan_reset_n)
      (st_ff == TAP_SHIFT_IR)[*4] |-> scan_out == $past(scan_in, 3))
      else $error("instruction path not three stages");
   AST_ID_CAP: assert property (@(posedge scan_clk) disable iff (!scan_reset_n)
      s_cap_id |-> scan_out) else $error("identification bit 0 wrong");
   AST_BYPASS: assert property (@(posedge scan_clk) disable iff (!scan_reset_n)
      s_byp |-> scan_out == $past(scan_in)) else $error("bypass path wrong");
   AST_TEST_RST: assert property (@(posedge mclk) disable iff (!rst_n)
      !scan_reset_n |-> !scan_out_oe) else $error("test reset did not stop output");
   AST_HIGHZ: assert property (@(posedge mclk) disable iff (!rst_n)
      (ir_ff == `BST_OP_HIGHZ)[*5] |-> pin_oe == '0) else $error("pins not floated");
   AST_CORE_IN: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(rst_n, 2) |-> core_in == $past(pin_in, 2))
      else $error("core input path wrong");
   AST_SYS_RST: assert property (@(posedge mclk) disable iff (!scan_reset_n)
      !rst_n |=> pin_oe == '0 && pin_out == '0) else $error("pins not cleared in reset");
endmodule // bst_tap_properties

bind bst_tap bst_tap_properties #(.NPIN(NPIN)) chk_u (.mclk(mclk), .rst_n(rst_n),
   .scan_clk(scan_clk), .scan_reset_n(scan_reset_n), .mode_select(mode_select),
   .scan_in(scan_in), .scan_out(scan_out), .scan_out_oe(scan_out_oe), .core_in(core_in),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

/* File: test/bst_tester.sv */
// Tester model: runs scans with a 15 ns scan clock that stands low between them.
// Assumes one caller at a time, starting from Run-Test-Idle.
module bst_tester (
   output logic scan_clk,
   output logic mode_select,
   output logic scan_in,
   input wire logic scan_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scan_clk = 1'b0;
      mode_select = 1'b1;
      scan_in = 1'b0;
   end
   // Inputs move while the clock is low; output is taken at the rise
   task automatic step(input logic ms, input logic si, output logic so);
      mode_select = ms;
      scan_in = si;
      #3.5 scan_clk = 1'b1;
      so = scan_out;
      #7.5 scan_clk = 1'b0;
      #4;
   endtask
   // Serial input flips outside shifting so a design that samples it there is caught
   task automatic walk(input logic ms);
      logic so;
      step(ms, ~scan_in, so);
   endtask
   task automatic to_idle();
      repeat (5) walk(1'b1);
      walk(1'b0);
   endtask
   task automatic scan(input logic ir, input int n, input int pz, input logic [63:0] din,
                       output logic [63:0] dout);
      dout = '0;
      walk(1'b1);
      if (ir) walk(1'b1);
      walk(1'b0);
      walk(1'b0);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || i == pz, din[i], dout[i]);
         if (i == pz) begin
            walk(1'b0);
            walk(1'b0);
            walk(1'b1);
            walk(1'b0);
         end
      end
      walk(1'b1);
      walk(1'b0);
   endtask
endmodule // bst_tester

/* File: test/tb_boundary_scan_tap.sv */
// Bench of the scan port: system side driven here, scan side by the tester model.
// Assumes the checker is bound to the port and the tester stops its clock between scans.
`include "bst_defs.svh"
module tb_boundary_scan_tap;
   timeunit 1ns;
   timeprecision 100ps;
   // Identification fields: arbitrary values
   localparam logic [31:0] ID = {4'h6, 16'hc3e1, 11'h2b7, 1'b1};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic scan_reset_n = 1'b0;
   logic [7:0] core_out, core_oe, pin_in;
   logic scan_clk, mode_select, scan_in, scan_out, scan_out_oe;
   logic [7:0] core_in, pin_out, pin_oe;
   logic [63:0] d;
   int fails = 0, n_tests = 0, cyc = 0;
   always #10 mclk = ~mclk;
   bst_tap #(.ID_VERSION(4'h6), .ID_PART(16'hc3e1), .ID_MAKER(11'h2b7)) dut_u (
      .mclk(mclk),
      .rst_n(rst_n),
      .scan_clk(scan_clk),
      .scan_reset_n(scan_reset_n),
      .mode_select(mode_select),
      .scan_in(scan_in),
      .scan_out(scan_out),
      .scan_out_oe(scan_out_oe),
      .core_out(core_out),
      .core_oe(core_oe),
      .core_in(core_in),
      .pin_in(pin_in),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );
   bst_tester tester_u (.scan_clk(scan_clk), .mode_select(mode_select), .scan_in(scan_in),
      .scan_out(scan_out));
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   // Pin changes need up to 4 system clocks to cross; 6 leaves margin
   task automatic sys(input logic [7:0] co, input logic [7:0] oe, input logic [7:0] pi);
      @(negedge mclk);
      core_out = co;
      core_oe = oe;
      pin_in = pi;
      repeat (6) @(negedge mclk);
   endtask
   task automatic ir(input logic [2:0] code);
      tester_u.scan(1'b1, 6, 4, {58'h0, code, ~code}, d);
      check(d[5:0], {~code, 3'h1});
   endtask
   task automatic t_sys();
      sys(8'ha5, 8'h3c, 8'h5e);
      check({pin_oe, pin_out, core_in}, 24'h3ca55e);
      $display("t_sys done");
   endtask
   task automatic t_id();
      tester_u.to_idle();
      tester_u.scan(1'b0, 32, 10, 64'h0, d);
      check(d[31:0], ID);
      ir(`BST_OP_BYPASS);
      scan_reset_n = 1'b0;
      #20 scan_reset_n = 1'b1;
      tester_u.walk(1'b0);
      tester_u.scan(1'b0, 32, -1, 64'h0, d);
      check(d[31:0], ID);
      $display("t_id done");
   endtask
   task automatic t_byp();
      logic [2:0] codes [3] = '{`BST_OP_BYPASS, 3'h5, 3'h6};
      foreach (codes[i]) begin
         ir(codes[i]);
         tester_u.scan(1'b0, 8, -1, 64'hb6, d);
         check(d[7:0], 8'h6c);
         sys(8'h0f, 8'hff, 8'h00);
         check({pin_oe, pin_out}, 16'hff0f);
      end
      $display("t_byp done");
   endtask
   task automatic t_bsr();
      ir(`BST_OP_SAMPLE);
      sys(8'h81, 8'hf0, 8'h96);
      tester_u.scan(1'b0, 24, -1, 64'h5ac33c, d);
      check(d[23:0], 24'hf08196);
      check({pin_oe, pin_out}, 16'hf081);
      ir(`BST_OP_EXTEST);
      sys(8'h81, 8'hf0, 8'h96);
      check({pin_oe, pin_out}, 16'h5ac3);
      tester_u.scan(1'b0, 24, -1, 64'h0fa500, d);
      check(d[23:0], 24'hf08196);
      sys(8'h81, 8'hf0, 8'h96);
      check({pin_oe, pin_out}, 16'h0fa5);
      ir(`BST_OP_CLAMP);
      sys(8'h11, 8'h22, 8'h96);
      check({pin_oe, pin_out}, 16'h0fa5);
      tester_u.scan(1'b0, 4, -1, 64'h9, d);
      check(d[3:0], 4'h2);
      ir(`BST_OP_HIGHZ);
      sys(8'h11, 8'h22, 8'h96);
      check(pin_oe, 8'h00);
      tester_u.scan(1'b0, 4, -1, 64'h5, d);
      check(d[3:0], 4'ha);
      repeat (3) tester_u.walk(1'b1);
      tester_u.walk(1'b0);
      sys(8'h11, 8'h22, 8'h96);
      check({pin_oe, pin_out}, 16'h2211);
      tester_u.scan(1'b0, 32, -1, 64'h0, d);
      check(d[31:0], ID);
      $display("t_bsr done");
   endtask
   initial begin
      core_out = 8'h00;
      core_oe = 8'h00;
      pin_in = 8'h00;
      #5 scan_reset_n = 1'b1;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      t_sys();
      t_id();
      t_byp();
      t_bsr();
      close_out();
   end
endmodule // tb_boundary_scan_tap
